// ==== logic/ofd_regs.svh ====
`ifndef OFD_REGS_SVH
`define OFD_REGS_SVH
// What this block does
// - Bits 15..8 = 00001000 is a static bit op; 7..6 pick test/change/clear/set.
// - Bit ops read one extension word, upper byte zero, bit number modulo 32.
// - Two-bit size field: 00 byte, 01 word, 10 long.
// - Immediate xor/compare fetch operand: byte low 8 bits, word 16 bits, long two words.
// - Alternate-space move extension: bit 15 address/data, 14..12 register, 11 direction.
// - General move: destination register 11..9, mode 8..6; address move mode 001.
// - Clear, negate, complement are one word with size and effective address.
// - Condition/status moves and decimal negate are one word, no size field.

// ---------------------------------------------------------------
// first-word patterns
// ---------------------------------------------------------------
`define OFD_BITOP_HI 8'h08
`define OFD_XOR_HI 8'h0A
`define OFD_CMP_HI 8'h0C
`define OFD_ALTMV_HI 8'h0E
`define OFD_XOR_CCR_WORD 16'h0A3C
`define OFD_XOR_SR_WORD 16'h0A7C
`define OFD_NEGATE_WITH_EXTEND_HI 8'h40
`define OFD_CLR_HI 8'h42
`define OFD_NEG_HI 8'h44
`define OFD_NOT_HI 8'h46
`define OFD_DECIMAL_NEGATE_TOP10 10'h120
`define OFD_GRP4_NIB 4'h4
`define OFD_LEA_OPM 3'h7
`define OFD_ADDR_MODE 3'h1

// ---------------------------------------------------------------
// field values
// ---------------------------------------------------------------
`define OFD_SIZE_RESERVED 2'h3
`define OFD_BIT_MOD_W 5
`endif

// ==== logic/ofd_pkg.sv ====
package ofd_pkg;
	typedef enum logic [4:0] {
		OFD_OP_ILLEGAL,
		OFD_OP_BIT_TEST,
		OFD_OP_BIT_CHANGE,
		OFD_OP_BIT_CLEAR,
		OFD_OP_BIT_SET,
		OFD_OP_IMMEDIATE_XOR,
		OFD_OP_IMMEDIATE_COMPARE,
		OFD_OP_XOR_CONDITION_CODE,
		OFD_OP_XOR_STATUS,
		OFD_OP_ALTERNATE_SPACE_MOVE,
		OFD_OP_MOVE,
		OFD_OP_ADDRESS_MOVE,
		OFD_OP_NEGATE_WITH_EXTEND,
		OFD_OP_MOVE_FROM_STATUS,
		OFD_OP_BOUNDS_CHECK,
		OFD_OP_LOAD_EFFECTIVE_ADDRESS,
		OFD_OP_OPERAND_CLEAR,
		OFD_OP_OPERAND_NEGATE,
		OFD_OP_OPERAND_COMPLEMENT,
		OFD_OP_MOVE_FROM_CONDITION_CODE,
		OFD_OP_MOVE_TO_CONDITION_CODE,
		OFD_OP_MOVE_TO_STATUS,
		OFD_OP_DECIMAL_NEGATE
	} ofd_op_t;

	typedef enum logic [1:0] {
		OFD_SIZE_BYTE,
		OFD_SIZE_WORD,
		OFD_SIZE_LONG,
		OFD_SIZE_NONE
	} ofd_size_t;
endpackage

// ==== logic/ofd_word_class.sv ====
`timescale 1ns/1ps
`include "ofd_regs.svh"
module ofd_word_class
	import ofd_pkg::*;
(
	input wire logic [15:0] word, // first instruction word
	output ofd_op_t op, // instruction class
	output ofd_size_t size, // operand size
	output logic [1:0] ext_count // extension words still to read
);
	// ---------------------------------------------------------------
	// size field decode
	// ---------------------------------------------------------------
	function automatic ofd_size_t size_of(input logic [1:0] code);
		unique case (code)
			2'h0: size_of = OFD_SIZE_BYTE;
			2'h1: size_of = OFD_SIZE_WORD;
			2'h2: size_of = OFD_SIZE_LONG;
			2'h3: size_of = OFD_SIZE_NONE;
		endcase
	endfunction

	logic sz76_bad;
	logic sz1312_bad;
	logic sz87_bad;
	assign sz76_bad = (word[7:6] == `OFD_SIZE_RESERVED);
	assign sz1312_bad = (word[13:12] == `OFD_SIZE_RESERVED);
	assign sz87_bad = (word[8:7] == `OFD_SIZE_RESERVED);

	// ---------------------------------------------------------------
	// classification, most specific pattern first
	// ---------------------------------------------------------------
	always_comb begin
		op = OFD_OP_ILLEGAL;
		size = OFD_SIZE_NONE;
		ext_count = 2'd0;
		if (word == `OFD_XOR_CCR_WORD) begin
			op = OFD_OP_XOR_CONDITION_CODE;
			size = OFD_SIZE_BYTE;
			ext_count = 2'd1;
		end else if (word == `OFD_XOR_SR_WORD) begin
			op = OFD_OP_XOR_STATUS;
			size = OFD_SIZE_WORD;
			ext_count = 2'd1;
		end else if (word[15:8] == `OFD_BITOP_HI) begin
			unique case (word[7:6])
				2'h0: op = OFD_OP_BIT_TEST;
				2'h1: op = OFD_OP_BIT_CHANGE;
				2'h2: op = OFD_OP_BIT_CLEAR;
				2'h3: op = OFD_OP_BIT_SET;
			endcase
			ext_count = 2'd1;
		end else if (word[15:8] == `OFD_XOR_HI || word[15:8] == `OFD_CMP_HI) begin
			if (!sz76_bad) begin
				op = (word[15:8] == `OFD_XOR_HI) ? OFD_OP_IMMEDIATE_XOR : OFD_OP_IMMEDIATE_COMPARE;
				size = size_of(word[7:6]);
				ext_count = (word[7:6] == 2'h2) ? 2'd2 : 2'd1;
			end
		end else if (word[15:8] == `OFD_ALTMV_HI) begin
			if (!sz76_bad) begin
				op = OFD_OP_ALTERNATE_SPACE_MOVE;
				size = size_of(word[7:6]);
				ext_count = 2'd1;
			end
		end else if (word[15:14] == 2'h0) begin
			if (!sz1312_bad) begin
				op = (word[8:6] == `OFD_ADDR_MODE) ? OFD_OP_ADDRESS_MOVE : OFD_OP_MOVE;
				size = size_of(word[13:12]);
			end
		end else if (word[15:12] == `OFD_GRP4_NIB) begin
			if (word[15:8] == `OFD_NEGATE_WITH_EXTEND_HI) begin
				op = sz76_bad ? OFD_OP_MOVE_FROM_STATUS : OFD_OP_NEGATE_WITH_EXTEND;
				size = size_of(word[7:6]);
			end else if (word[15:8] == `OFD_CLR_HI) begin
				op = sz76_bad ? OFD_OP_MOVE_FROM_CONDITION_CODE : OFD_OP_OPERAND_CLEAR;
				size = size_of(word[7:6]);
			end else if (word[15:8] == `OFD_NEG_HI) begin
				op = sz76_bad ? OFD_OP_MOVE_TO_CONDITION_CODE : OFD_OP_OPERAND_NEGATE;
				size = size_of(word[7:6]);
			end else if (word[15:8] == `OFD_NOT_HI) begin
				op = sz76_bad ? OFD_OP_MOVE_TO_STATUS : OFD_OP_OPERAND_COMPLEMENT;
				size = size_of(word[7:6]);
			end else if (word[15:6] == `OFD_DECIMAL_NEGATE_TOP10) begin
				op = OFD_OP_DECIMAL_NEGATE;
			end else if (word[8:6] == `OFD_LEA_OPM) begin
				op = OFD_OP_LOAD_EFFECTIVE_ADDRESS;
				size = OFD_SIZE_LONG;
			end else if (!word[6] && !sz87_bad) begin
				op = OFD_OP_BOUNDS_CHECK;
				size = size_of(word[8:7]);
			end
		end
		// anything left as illegal carries no size and no extension
	end
endmodule

// ==== logic/ofd_decoder.sv ====
`timescale 1ns/1ps
`include "ofd_regs.svh"
module ofd_decoder
	import ofd_pkg::*;
(
	input wire logic clk_sys, // 20 MHz core clock
	input wire logic resetn, // async reset, active low
	input wire logic word_valid, // fetch offers a word
	input wire logic [15:0] word_data, // fetched word
	output logic word_ready, // decoder takes the word
	output logic dec_valid, // decoded instruction held
	input wire logic dec_ready, // execution takes the result
	output ofd_op_t dec_op, // instruction class
	output ofd_size_t dec_size, // operand size
	output logic [2:0] dec_ea_mode, // source/operand mode
	output logic [2:0] dec_ea_reg, // source/operand register
	output logic [2:0] dec_dst_mode, // move destination mode
	output logic [2:0] dec_dst_reg, // move / lea / bounds register
	output logic [4:0] dec_bit_number, // bit number modulo 32
	output logic [31:0] dec_immediate, // immediate operand
	output logic dec_reg_is_addr, // alternate move: address register
	output logic [2:0] dec_reg_num, // alternate move register
	output logic dec_direction_bit, // 1 register to memory
	output logic dec_illegal, // illegal instruction flag
	output logic [15:0] dec_opcode // first word as taken
);
	typedef enum logic [1:0] {
		OFD_ST_OPCODE,
		OFD_ST_EXT1,
		OFD_ST_EXT2
	} ofd_state_t;

	ofd_state_t state;
	ofd_op_t cls_op;
	ofd_size_t cls_size;
	logic [1:0] cls_ext;
	logic take;
	logic ext_bad;

	ofd_word_class u_class (
		.word(word_data),
		.op(cls_op),
		.size(cls_size),
		.ext_count(cls_ext)
	);

	// ---------------------------------------------------------------
	// handshake
	// ---------------------------------------------------------------
	assign word_ready = !dec_valid || dec_ready;
	assign take = word_valid && word_ready;

	// extension words that must carry a zero upper byte
	assign ext_bad = (state == OFD_ST_EXT1) && (word_data[15:8] != 8'h00) &&
		(dec_op inside {OFD_OP_BIT_TEST, OFD_OP_BIT_CHANGE, OFD_OP_BIT_CLEAR, OFD_OP_BIT_SET,
		OFD_OP_XOR_CONDITION_CODE});

	// ---------------------------------------------------------------
	// sequencing of first and extension words
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= OFD_ST_OPCODE;
		end else if (take) begin
			unique case (state)
				OFD_ST_OPCODE: begin
					if (cls_ext != 2'd0) begin
						state <= OFD_ST_EXT1;
					end
				end
				OFD_ST_EXT1: begin
					state <= (dec_op inside {OFD_OP_IMMEDIATE_XOR, OFD_OP_IMMEDIATE_COMPARE} &&
						dec_size == OFD_SIZE_LONG) ? OFD_ST_EXT2 : OFD_ST_OPCODE;
				end
				OFD_ST_EXT2: begin
					state <= OFD_ST_OPCODE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dec_valid <= 1'b0;
		end else if (take) begin
			dec_valid <= (state == OFD_ST_OPCODE) ? (cls_ext == 2'd0) :
				(state == OFD_ST_EXT2) || !(dec_op inside {OFD_OP_IMMEDIATE_XOR, OFD_OP_IMMEDIATE_COMPARE} &&
				dec_size == OFD_SIZE_LONG);
		end else if (dec_ready) begin
			dec_valid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// first word fields
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dec_op <= OFD_OP_ILLEGAL;
			dec_size <= OFD_SIZE_NONE;
			dec_ea_mode <= 3'h0;
			dec_ea_reg <= 3'h0;
			dec_dst_mode <= 3'h0;
			dec_dst_reg <= 3'h0;
			dec_opcode <= 16'h0000;
		end else if (take && state == OFD_ST_OPCODE) begin
			dec_op <= cls_op;
			dec_size <= cls_size;
			dec_ea_mode <= word_data[5:3];
			dec_ea_reg <= word_data[2:0];
			dec_dst_mode <= (cls_op == OFD_OP_ADDRESS_MOVE) ? `OFD_ADDR_MODE : word_data[8:6];
			dec_dst_reg <= word_data[11:9];
			dec_opcode <= word_data;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dec_illegal <= 1'b0;
		end else if (take && state == OFD_ST_OPCODE) begin
			dec_illegal <= (cls_op == OFD_OP_ILLEGAL);
		end else if (take && ext_bad) begin
			dec_illegal <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// extension word fields
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dec_bit_number <= 5'h00;
			dec_immediate <= 32'h0000_0000;
			dec_reg_is_addr <= 1'b0;
			dec_reg_num <= 3'h0;
			dec_direction_bit <= 1'b0;
		end else if (take && state == OFD_ST_OPCODE) begin
			dec_bit_number <= 5'h00;
			dec_immediate <= 32'h0000_0000;
			dec_reg_is_addr <= 1'b0;
			dec_reg_num <= 3'h0;
			dec_direction_bit <= 1'b0;
		end else if (take && state == OFD_ST_EXT1) begin
			dec_bit_number <= word_data[`OFD_BIT_MOD_W-1:0];
			dec_reg_is_addr <= word_data[15];
			dec_reg_num <= word_data[14:12];
			dec_direction_bit <= word_data[11];
			if (dec_size == OFD_SIZE_BYTE) begin
				dec_immediate <= {24'h00_0000, word_data[7:0]};
			end else if (dec_size == OFD_SIZE_LONG) begin
				dec_immediate <= {word_data, 16'h0000};
			end else begin
				dec_immediate <= {16'h0000, word_data};
			end
		end else if (take && state == OFD_ST_EXT2) begin
			dec_immediate <= {dec_immediate[31:16], word_data};
		end
	end
endmodule

// ==== dv/ofd_decoder_monitor.sv ====
`timescale 1ns/1ps
module ofd_decoder_monitor
	import ofd_pkg::*;
(
	input wire logic clk_sys, // clock
	input wire logic resetn, // reset
	input wire logic word_valid, // offer
	input wire logic [15:0] word_data, // word
	input wire logic word_ready, // take
	input wire logic dec_valid, // result
	input wire ofd_op_t dec_op, // class
	input wire ofd_size_t dec_size, // size
	input wire logic [2:0] dec_dst_mode, // dst mode
	input wire logic [2:0] dec_dst_reg, // dst reg
	input wire logic [4:0] dec_bit_number, // bit
	input wire logic [31:0] dec_immediate, // imm
	input wire logic dec_reg_is_addr, // a/d
	input wire logic [2:0] dec_reg_num, // reg
	input wire logic dec_direction_bit, // dir
	input wire logic dec_illegal // illegal
);
	logic [1:0] pend;
	logic [15:0] cur;
	logic [15:0] ext1;
	wire logic take = word_valid && word_ready;
	// extension words that follow a first word
	function automatic logic [1:0] f_need(input logic [15:0] w);
		if (w[15:8] == 8'h08) return 2'h1;
		// only long immediates take two words; the alternate-space move (bits 10:9 = 11) takes one
		if (w[15:8] inside {8'h0A, 8'h0C, 8'h0E} && w[7:6] != 2'h3)
			return (w[7:6] == 2'h2 && w[10:9] != 2'h3) ? 2'h2 : 2'h1;
		return 2'h0;
	endfunction
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pend <= 2'h0;
			cur <= 16'h0000;
			ext1 <= 16'h0000;
		end else if (take) begin
			if (pend == 2'h0) begin
				cur <= word_data;
				pend <= f_need(word_data);
			end else begin
				pend <= pend - 2'h1;
				ext1 <= word_data;
			end
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence s_op(c); take && pend == 2'h0 && c; endsequence
	sequence s_last(c); take && pend == 2'h1 && c; endsequence
	property p_bit; s_last(cur[15:8] == 8'h08) |=> dec_valid && dec_op == OFD_OP_BIT_TEST + cur[7:6]; endproperty
	a_bit: assert property (p_bit) else $error("bit class");
	property p_num;
		s_last(cur[15:8] == 8'h08) |=> dec_bit_number == $past(word_data[4:0]) &&
			dec_illegal == ($past(word_data[15:8]) != 8'h00);
	endproperty
	a_num: assert property (p_num) else $error("bit number");
	property p_size;
		s_op(word_data[15:8] inside {8'h42, 8'h44, 8'h46}) |=>
			dec_valid && dec_size == $past(word_data[7:6]);
	endproperty
	a_size: assert property (p_size) else $error("size");
	property p_long;
		s_last(cur[15:8] inside {8'h0A, 8'h0C} && cur[7:6] == 2'h2) |=>
			dec_valid && dec_immediate == {$past(ext1), $past(word_data)};
	endproperty
	a_long: assert property (p_long) else $error("long imm");
	property p_ccr;
		s_last(cur == 16'h0A3C) |=> dec_op == OFD_OP_XOR_CONDITION_CODE &&
			dec_immediate == {24'h00_0000, $past(word_data[7:0])};
	endproperty
	a_ccr: assert property (p_ccr) else $error("ccr imm");
	property p_alt;
		s_last(cur[15:8] == 8'h0E) |=>
			{dec_reg_is_addr, dec_reg_num, dec_direction_bit} == $past(word_data[15:11]);
	endproperty
	a_alt: assert property (p_alt) else $error("alt ext");
	property p_amove; s_op(word_data[15:14] == 2'h0 && word_data[13:12] inside {2'h1, 2'h2} && word_data[8:6] == 3'h1)
		|=> dec_op == OFD_OP_ADDRESS_MOVE && dec_dst_mode == 3'h1 && dec_dst_reg == $past(word_data[11:9]); endproperty
	a_amove: assert property (p_amove) else $error("addr move");
	property p_clr;
		s_op(word_data[15:8] == 8'h42 && word_data[7:6] != 2'h3) |=> dec_valid && dec_op == OFD_OP_OPERAND_CLEAR;
	endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_decimal_negate; s_op(word_data[15:6] == 10'h120) |=> dec_op == OFD_OP_DECIMAL_NEGATE && dec_size == OFD_SIZE_NONE; endproperty
	a_decimal_negate: assert property (p_decimal_negate) else $error("dec negate");
	property p_lea; s_op(word_data[15:12] == 4'h4 && word_data[8:6] == 3'h7) |=> dec_op == OFD_OP_LOAD_EFFECTIVE_ADDRESS; endproperty
	a_lea: assert property (p_lea) else $error("lea");
	property p_ill; s_op(word_data[15:14] == 2'h3) |=> dec_valid && dec_illegal && dec_op == OFD_OP_ILLEGAL; endproperty
	a_ill: assert property (p_ill) else $error("illegal");
endmodule
bind ofd_decoder ofd_decoder_monitor u_ofd_decoder_monitor (.*);

// ==== dv/ofd_fetch_model.sv ====
`timescale 1ns/1ps
module ofd_fetch_model (
	input wire logic clk_sys, // clock
	input wire logic resetn, // reset
	input wire logic word_ready, // take
	output logic word_valid, // offer
	output logic [15:0] word_data // word
);
	logic [15:0] q[$];
	int slow = 0;
	logic took = 0;
	task automatic push(input logic [15:0] w);
		q.push_back(w);
	endtask
	initial begin
		word_valid = 0;
		word_data = 16'h0000;
	end
	always @(posedge clk_sys) begin
		took = word_valid && word_ready;
		if (took) void'(q.pop_front());
	end
	// an offer stands until taken; idle data toggles
	always @(negedge clk_sys) begin
		if (!resetn || !(word_valid && !took)) begin
			word_valid = resetn && q.size() > 0 && $urandom_range(3) >= slow;
			word_data = word_valid ? q[0] : ~word_data;
		end
	end
endmodule

// ==== dv/opcode_field_decoder_tb.sv ====
`timescale 1ns/1ps
module opcode_field_decoder_tb;
	import ofd_pkg::*;
	typedef struct {logic [15:0] w; logic [15:0] e1; logic [31:0] imm; int op; int sz; int ill;} ofd_exp_t;
	logic clk_sys = 0;
	logic resetn = 0;
	logic dec_ready = 0;
	logic rnd = 0;
	logic word_valid, word_ready, dec_valid, dec_reg_is_addr, dec_direction_bit, dec_illegal;
	logic [15:0] word_data, dec_opcode;
	ofd_op_t dec_op;
	ofd_size_t dec_size;
	logic [2:0] dec_ea_mode, dec_ea_reg, dec_dst_mode, dec_dst_reg, dec_reg_num;
	logic [4:0] dec_bit_number;
	logic [31:0] dec_immediate;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	ofd_exp_t eq[$];
	logic [15:0] dir[] = '{16'h08C5, 16'h0803, 16'h0845, 16'h0887, 16'h0A3C, 16'h0A7C, 16'h0C80, 16'h0A45, 16'h0E10,
		16'h0E9F, 16'h1001, 16'h2E48, 16'h40D0, 16'h4090, 16'h42C0, 16'h44C0, 16'h46C0, 16'h4812, 16'h45C3,
		16'h4A85, 16'h4D3A, 16'hFFFF, 16'h0AC0, 16'h0EC1, 16'h4E71, 16'h3201};
	logic [15:0] base[] = '{16'h0800, 16'h0A00, 16'h0C00, 16'h0E00, 16'h4000, 16'h4200, 16'h4400, 16'h4600,
		16'h1000, 16'h2000, 16'h4800, 16'h41C0};
	logic [15:0] mask[] = '{16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF,
		16'h0FFF, 16'h0FFF, 16'h003F, 16'h0E3F};
	initial forever #25 clk_sys = ~clk_sys;
	ofd_decoder u_ofd_decoder (.*);
	ofd_fetch_model u_ofd_fetch_model (.*);
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// reference decode of one instruction, queued with its words
	task automatic inst(input logic [15:0] w);
		ofd_exp_t e;
		logic [7:0] h;
		logic [1:0] s;
		logic [15:0] e2;
		int n;
		h = w[15:8];
		s = w[7:6];
		e.w = w;
		e.op = OFD_OP_ILLEGAL;
		e.sz = -1;
		n = 0;
		e.e1 = 16'($urandom);
		e2 = 16'($urandom);
		if ($urandom_range(3) != 0) e.e1[15:8] = 8'h00;
		if (h == 8'h08) begin
			e.op = OFD_OP_BIT_TEST + s;
			n = 1;
		end else if (w == 16'h0A3C || w == 16'h0A7C) begin
			e.op = w[6] ? OFD_OP_XOR_STATUS : OFD_OP_XOR_CONDITION_CODE;
			n = 1;
		end else if (h inside {8'h0A, 8'h0C, 8'h0E}) begin
			if (s != 3) begin
				e.sz = s;
				e.op = h == 8'h0A ? OFD_OP_IMMEDIATE_XOR : h == 8'h0C ? OFD_OP_IMMEDIATE_COMPARE : OFD_OP_ALTERNATE_SPACE_MOVE;
				n = (s == 2 && h != 8'h0E) ? 2 : 1;
			end
		end else if (w[15:14] == 0) begin
			// size code 11 in bits 13:12 is reserved and stays illegal
			if (w[13:12] != 3) begin
				e.op = w[8:6] == 1 ? OFD_OP_ADDRESS_MOVE : OFD_OP_MOVE;
				e.sz = w[13:12];
			end
		end else if (h inside {8'h40, 8'h42, 8'h44, 8'h46}) begin
			e.sz = s;
			if (h == 8'h40) e.op = s == 3 ? OFD_OP_MOVE_FROM_STATUS : OFD_OP_NEGATE_WITH_EXTEND;
			else e.op = (s == 3 ? OFD_OP_MOVE_FROM_CONDITION_CODE : OFD_OP_OPERAND_CLEAR) + h[2:1] - 1;
		end else if (w[15:6] == 10'h120) begin
			e.op = OFD_OP_DECIMAL_NEGATE;
			e.sz = 3;
		end else if (w[15:12] == 4 && w[8:6] == 7) begin
			e.op = OFD_OP_LOAD_EFFECTIVE_ADDRESS;
		end else if (w[15:12] == 4 && !w[6] && w[8:7] != 3) begin
			e.op = OFD_OP_BOUNDS_CHECK;
			e.sz = w[8:7];
		end
		e.imm = n == 2 ? {e.e1, e2} : (e.sz == 0 || w == 16'h0A3C) ? {24'h0, e.e1[7:0]} : {16'h0, e.e1};
		e.ill = e.op == OFD_OP_ILLEGAL || ((h == 8'h08 || w == 16'h0A3C) && e.e1[15:8] != 0);
		u_ofd_fetch_model.push(w);
		if (n > 0) u_ofd_fetch_model.push(e.e1);
		if (n > 1) u_ofd_fetch_model.push(e2);
		eq.push_back(e);
	endtask
	task automatic cmp();
		ofd_exp_t e;
		if (eq.size() == 0) begin
			chk("extra", 1, 0);
			return;
		end
		e = eq.pop_front();
		chk("opcode", dec_opcode, e.w);
		chk("illegal", dec_illegal, e.ill);
		chk("ea", {dec_ea_mode, dec_ea_reg}, e.w[5:0]);
		chk("dst", {dec_dst_reg, dec_dst_mode}, e.w[11:6]);
		if (!e.ill) chk("op", dec_op, e.op);
		if (e.sz >= 0) chk("size", dec_size, e.sz);
		if (e.w[15:8] == 8'h08 && !e.ill) chk("bit", dec_bit_number, e.e1[4:0]);
		if (e.op inside {[OFD_OP_IMMEDIATE_XOR:OFD_OP_XOR_STATUS]} && !e.ill) chk("imm", dec_immediate, e.imm);
		if (e.op == OFD_OP_ALTERNATE_SPACE_MOVE) chk("alt", {dec_reg_is_addr, dec_reg_num, dec_direction_bit}, e.e1[15:11]);
	endtask
	always @(negedge clk_sys) dec_ready <= rnd ? $urandom_range(2) != 0 : 1'b1;
	always @(posedge clk_sys) if (resetn && dec_valid === 1'b1 && dec_ready) cmp();
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(39952));
		repeat (3) @(negedge clk_sys);
		resetn = 1;
		chk("reset", {word_ready, dec_valid, dec_illegal, dec_op}, 8'h80);
		foreach (dir[i]) inst(dir[i]);
		wait (eq.size() == 0);
		rnd = 1;
		u_ofd_fetch_model.slow = 2;
		for (int i = 0; i < 400; i++) inst(base[i % 12] | (mask[i % 12] & 16'($urandom)));
		wait (eq.size() == 0);
		repeat (3) @(posedge clk_sys);
		print_verdict();
	end
endmodule
